// ===== rsp_pkg.sv
// Constants and types shared by the return stack and fast context pipeline.
// How it works
// - Stack index is bits 4..0, writable, resets zero.
// - Bit 7 shows stack full or overflowed.
// - Bit 6 shows a stack underflow occurred.
// - Flags cleared only by software or power-on.
// - Overflow reset enabled: set flag, then reset.
// - Overflow reset disabled: set flag, no reset.
// - Hidden one-deep shadows for status, working, bank.
// - Interrupt vectoring loads all three shadows.
// - Fast interrupt return restores from shadows.
// - High priority entry overwrites low priority shadows.
// - Fast call saves, fast return restores shadows.
// - Adding working register to pc_low_byte jumps bytes.
// - Table access uses byte pointer and data latch.
// - Core clock divided into four phases per cycle.
// - PC increments in phase_one; fetch latched phase_four.
// - Fetch of next overlaps execute of current.
// - PC-changing instructions flush fetch, take two cycles.
// - Operand read phase_two, result written phase_four.
// - Push increments then writes; pop reads then decrements.
// - Full flag set after 31 unpopped pushes.
// - Reset disabled: extra pushes keep index 31, no overwrite.
// - Empty pop returns zero, sets underflow, index stays zero.
package rsp_pkg;
  localparam logic [11:0] RSP_STACK_CTRL_ADDR = 12'h000;
  localparam logic [11:0] RSP_TABLE_PTR_ADDR = 12'h004;
  localparam logic [11:0] RSP_TABLE_LATCH_ADDR = 12'h008;
  localparam logic [11:0] RSP_CONFIG_ADDR = 12'h00c;
  localparam logic [11:0] RSP_PC_ADDR = 12'h010;
  localparam int RSP_FULL_BIT = 7;
  localparam int RSP_UNF_BIT = 6;
  localparam int RSP_INDEX_MSB = 4;
  localparam logic [4:0] RSP_INDEX_RESET = 5'h00;
  localparam logic [4:0] RSP_INDEX_MAX = 5'h1f;
  localparam logic [7:0] RSP_CTRL_RESET = 8'h00;
  localparam logic RSP_OVF_RESET_DEFAULT = 1'b1;
  localparam int RSP_PHASES = 4;
  localparam int RSP_PC_W = 21;
  localparam logic [20:0] RSP_PC_STEP = 21'h000002;
  localparam logic [20:0] RSP_PC_RESET = 21'h000000;
  typedef enum logic [3:0] {
    RSP_PH_ONE = 4'b0001,
    RSP_PH_TWO = 4'b0010,
    RSP_PH_THREE = 4'b0100,
    RSP_PH_FOUR = 4'b1000
  } rsp_phase_type;
  typedef enum logic [2:0] {
    RSP_OP_NONE = 3'h0,
    RSP_OP_CALL = 3'h1,
    RSP_OP_RETURN = 3'h2,
    RSP_OP_RETURN_FROM_INTERRUPT = 3'h3,
    RSP_OP_GOTO = 3'h4,
    RSP_OP_ADD_PCL = 3'h5,
    RSP_OP_SEQ = 3'h6
  } rsp_op_type;
endpackage

// ===== rsp_phase_if.sv
// Phase strobes shared between the phase generator and the core logic.
`timescale 1ns/1ps
interface rsp_phase_if;
  logic ph_one;
  logic ph_two;
  logic ph_three;
  logic ph_four;
  modport gen(output ph_one, output ph_two, output ph_three, output ph_four);
  modport use_p(input ph_one, input ph_two, input ph_three, input ph_four);
endinterface

// ===== rsp_phase_gen.sv
// Divide-by-four phase generator producing one-cycle phase strobes.
`timescale 1ns/1ps
module rsp_phase_gen (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_in,
  // Phase strobes.
  rsp_phase_if.gen ph
);
  import rsp_pkg::*;
  rsp_phase_type phase_q;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      phase_q <= RSP_PH_ONE;
    end else begin
      case (phase_q)
        RSP_PH_ONE: phase_q <= RSP_PH_TWO;
        RSP_PH_TWO: phase_q <= RSP_PH_THREE;
        RSP_PH_THREE: phase_q <= RSP_PH_FOUR;
        RSP_PH_FOUR: phase_q <= RSP_PH_ONE;
        default: phase_q <= RSP_PH_ONE;
      endcase
    end
  end
  assign ph.ph_one = phase_q[0];
  assign ph.ph_two = phase_q[1];
  assign ph.ph_three = phase_q[2];
  assign ph.ph_four = phase_q[3];
  AST_PHASE_ONEHOT: assert property (@(posedge clk_in) disable iff (rst_in)
    $onehot(phase_q)) else $error("phase not one-hot");
  // The sampled reset term skips the edge at which reset is released.
  AST_PHASE_ORDER: assert property (@(posedge clk_in) disable iff (rst_in)
    phase_q[0] && !rst_in |=> phase_q[1] ##1 phase_q[2] ##1 phase_q[3])
    else $error("phase sequence broken");
endmodule

// ===== rsp_core.sv
// Return stack, fast shadow registers, table access and fetch/execute pipeline.
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module rsp_core (
  // Clock and power-on reset.
  input wire logic clk_in,
  input wire logic rst_in,
  // APB slave.
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Program memory fetch and table access.
  output logic [20:0] fetch_addr_out,
  input wire logic [15:0] fetch_word_in,
  output logic [15:0] instr_reg_out,
  output logic table_read_out,
  input wire logic [7:0] table_byte_in,
  // Executed operation from the decoder.
  input wire rsp_pkg::rsp_op_type exec_op_in,
  input wire logic exec_fast_in,
  input wire logic [20:0] branch_target_in,
  // Interrupt vectoring.
  input wire logic irq_vector_in,
  input wire logic [20:0] irq_vector_addr_in,
  // Live context registers and data memory.
  input wire logic [7:0] status_in,
  input wire logic [7:0] working_register_in,
  input wire logic [3:0] bank_select_register_in,
  output logic restore_out,
  output logic [7:0] status_restore_out,
  output logic [7:0] working_register_restore_out,
  output logic [3:0] bank_select_register_restore_out,
  output logic operand_read_out,
  output logic result_write_out,
  // Device reset request.
  output logic device_reset_out,
  // Phase strobes.
  output logic phase_one_out,
  output logic phase_four_out
);
  import rsp_pkg::*;
  rsp_phase_if ph();
  rsp_phase_gen u_phase (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ph(ph.gen)
  );

  logic [4:0] index_q;
  logic full_q;
  logic unf_q;
  logic [20:0] stack_q [1:31];
  logic [20:0] pc_q;
  logic [15:0] ir_q;
  logic flush_q;
  logic [7:0] sh_status_q;
  logic [7:0] sh_working_q;
  logic [3:0] sh_bank_q;
  logic [21:0] tbl_ptr_q;
  logic [7:0] tbl_latch_q;
  logic ovf_reset_en_q;
  logic dev_reset_q;
  logic restore_q;
  logic table_rd_q;
  logic [7:0] ctrl_rd;

  // Stack events evaluated at phase_four of the execute cycle.
  logic exe;
  logic do_push;
  logic do_pop;
  logic push_full;
  logic pop_empty;
  logic pc_change;
  assign exe = ph.ph_four && !flush_q;
  assign do_push = (exe && exec_op_in == RSP_OP_CALL) || irq_vector_in && ph.ph_four;
  assign do_pop = exe && (exec_op_in == RSP_OP_RETURN || exec_op_in == RSP_OP_RETURN_FROM_INTERRUPT);
  assign push_full = do_push && index_q >= RSP_INDEX_MAX - 5'h01;
  assign pop_empty = do_pop && index_q == RSP_INDEX_RESET;
  assign pc_change = do_push || do_pop ||
    (exe && (exec_op_in == RSP_OP_GOTO || exec_op_in == RSP_OP_ADD_PCL));

  // APB access: zero-wait, single-cycle access phase.
  logic wr;
  logic rd;
  assign wr = psel_in && penable_in && pwrite_in;
  assign rd = psel_in && !pwrite_in;
  assign pready_out = 1'b1;
  assign pslverr_out = 1'b0;
  assign ctrl_rd = {full_q, unf_q, 1'b0, index_q};

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      prdata_out <= 32'h00000000;
    end else if (rd) begin
      case (paddr_in)
        RSP_STACK_CTRL_ADDR: prdata_out <= {24'h000000, ctrl_rd};
        RSP_TABLE_PTR_ADDR: prdata_out <= {10'h000, tbl_ptr_q};
        RSP_TABLE_LATCH_ADDR: prdata_out <= {24'h000000, tbl_latch_q};
        RSP_CONFIG_ADDR: prdata_out <= {31'h00000000, ovf_reset_en_q};
        RSP_PC_ADDR: prdata_out <= {11'h000, pc_q};
        default: prdata_out <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ovf_reset_en_q <= RSP_OVF_RESET_DEFAULT;
    end else if (wr && paddr_in == RSP_CONFIG_ADDR) begin
      ovf_reset_en_q <= pwdata_in[0];
    end
  end

  // Stack index: software write loses to a same-cycle stack operation.
  always_ff @(posedge clk_in) begin
    if (rst_in || dev_reset_q) begin
      index_q <= RSP_INDEX_RESET;
    end else if (push_full && ovf_reset_en_q) begin
      index_q <= RSP_INDEX_RESET;
    end else if (do_push) begin
      if (index_q != RSP_INDEX_MAX) begin
        index_q <= index_q + 5'h01;
      end
    end else if (do_pop) begin
      if (index_q != RSP_INDEX_RESET) begin
        index_q <= index_q - 5'h01;
      end
    end else if (wr && paddr_in == RSP_STACK_CTRL_ADDR) begin
      index_q <= pwdata_in[RSP_INDEX_MSB:0];
    end
  end

  // Flags survive device reset; only power-on or a software zero clears them.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      full_q <= 1'b0;
      unf_q <= 1'b0;
    end else begin
      if (push_full) begin
        full_q <= 1'b1;
      end else if (wr && paddr_in == RSP_STACK_CTRL_ADDR && !pwdata_in[RSP_FULL_BIT]) begin
        full_q <= 1'b0;
      end
      if (pop_empty) begin
        unf_q <= 1'b1;
      end else if (wr && paddr_in == RSP_STACK_CTRL_ADDR && !pwdata_in[RSP_UNF_BIT]) begin
        unf_q <= 1'b0;
      end
    end
  end

  // Device reset is raised at the same edge as the flag is set.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      dev_reset_q <= 1'b0;
    end else begin
      dev_reset_q <= ovf_reset_en_q && (push_full || pop_empty);
    end
  end
  assign device_reset_out = dev_reset_q;

  // Return address storage; entry 31 is never overwritten once full.
  always_ff @(posedge clk_in) begin
    if (do_push && index_q != RSP_INDEX_MAX) begin
      stack_q[index_q + 5'h01] <= pc_q;
    end
  end

  // Program counter and fetch pipeline.
  always_ff @(posedge clk_in) begin
    if (rst_in || dev_reset_q) begin
      pc_q <= RSP_PC_RESET;
      ir_q <= 16'h0000;
      flush_q <= 1'b1;
    end else begin
      if (ph.ph_one) begin
        pc_q <= pc_q + RSP_PC_STEP;
      end
      if (ph.ph_four) begin
        ir_q <= fetch_word_in;
        flush_q <= pc_change;
        if (irq_vector_in) begin
          pc_q <= irq_vector_addr_in;
        end else if (do_pop) begin
          pc_q <= pop_empty ? RSP_PC_RESET : stack_q[index_q];
        end else if (exe && (exec_op_in == RSP_OP_CALL || exec_op_in == RSP_OP_GOTO)) begin
          pc_q <= branch_target_in;
        end else if (exe && exec_op_in == RSP_OP_ADD_PCL) begin
          pc_q <= {pc_q[20:8], pc_q[7:0] + working_register_in} & ~21'h000001;
        end
      end
    end
  end
  assign fetch_addr_out = pc_q;
  assign instr_reg_out = ir_q;

  // Fast shadow registers, invisible to software.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sh_status_q <= 8'h00;
      sh_working_q <= 8'h00;
      sh_bank_q <= 4'h0;
    end else if ((irq_vector_in && ph.ph_four) ||
        (exe && exec_op_in == RSP_OP_CALL && exec_fast_in)) begin
      sh_status_q <= status_in;
      sh_working_q <= working_register_in;
      sh_bank_q <= bank_select_register_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      restore_q <= 1'b0;
    end else begin
      restore_q <= do_pop && exec_fast_in;
    end
  end
  assign restore_out = restore_q;
  assign status_restore_out = sh_status_q;
  assign working_register_restore_out = sh_working_q;
  assign bank_select_register_restore_out = sh_bank_q;

  // Table access: one byte per read into the latch.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tbl_ptr_q <= 22'h000000;
      tbl_latch_q <= 8'h00;
      table_rd_q <= 1'b0;
    end else begin
      table_rd_q <= rd && penable_in && paddr_in == RSP_TABLE_LATCH_ADDR;
      if (table_rd_q) begin
        tbl_latch_q <= table_byte_in;
        tbl_ptr_q <= tbl_ptr_q + 22'h000001;
      end else if (wr && paddr_in == RSP_TABLE_PTR_ADDR) begin
        tbl_ptr_q <= pwdata_in[21:0];
      end else if (wr && paddr_in == RSP_TABLE_LATCH_ADDR) begin
        tbl_latch_q <= pwdata_in[7:0];
      end
    end
  end
  assign table_read_out = table_rd_q;

  // Data memory strobes during non-flushed execute cycles.
  assign operand_read_out = ph.ph_two && !flush_q;
  assign result_write_out = ph.ph_four && !flush_q;
  assign phase_one_out = ph.ph_one;
  assign phase_four_out = ph.ph_four;

  AST_FULL_SETS: assert property (@(posedge clk_in) disable iff (rst_in)
    push_full |=> full_q) else $error("full flag not set");
  AST_UNF_SETS: assert property (@(posedge clk_in) disable iff (rst_in)
    pop_empty |=> unf_q && index_q == 5'h00) else $error("underflow not flagged");
  AST_STICKY: assert property (@(posedge clk_in) disable iff (rst_in)
    full_q && !(wr && paddr_in == RSP_STACK_CTRL_ADDR) |=> full_q)
    else $error("full flag cleared by hardware");
  AST_OVF_RESET: assert property (@(posedge clk_in) disable iff (rst_in)
    ovf_reset_en_q && pop_empty |=> device_reset_out) else $error("no reset");
  AST_NO_RESET: assert property (@(posedge clk_in) disable iff (rst_in)
    !ovf_reset_en_q |=> !device_reset_out) else $error("spurious reset");
  AST_INDEX_HOLD: assert property (@(posedge clk_in) disable iff (rst_in)
    !ovf_reset_en_q && do_push && index_q == 5'h1f |=> index_q == 5'h1f)
    else $error("index moved past 31");
  AST_BIT5_ZERO: assert property (@(posedge clk_in) disable iff (rst_in)
    rd && penable_in && paddr_in == RSP_STACK_CTRL_ADDR |=> !prdata_out[5])
    else $error("bit 5 not zero");
  AST_SHADOW_LOAD: assert property (@(posedge clk_in) disable iff (rst_in)
    irq_vector_in && ph.ph_four |=> sh_working_q == $past(working_register_in))
    else $error("shadow not loaded");
  // Sampled reset terms skip the edge at which a power-on or device reset ends.
  AST_PC_STEP: assert property (@(posedge clk_in) disable iff (rst_in || dev_reset_q)
    ph.ph_one && !rst_in && !dev_reset_q |=> pc_q == $past(pc_q) + 21'h000002)
    else $error("pc not stepped");
  AST_FLUSH: assert property (@(posedge clk_in) disable iff (rst_in || dev_reset_q)
    pc_change |=> flush_q [*4]) else $error("no flush after branch");
  AST_UNF_STICKY: assert property (@(posedge clk_in) disable iff (rst_in)
    unf_q && !(wr && paddr_in == RSP_STACK_CTRL_ADDR) |=> unf_q)
    else $error("underflow flag cleared by hardware");
  AST_PUSH_INDEX: assert property (@(posedge clk_in) disable iff (rst_in)
    do_push && !push_full && !dev_reset_q |=> index_q == $past(index_q) + 5'h01)
    else $error("push did not advance index");
  AST_POP_INDEX: assert property (@(posedge clk_in) disable iff (rst_in)
    do_pop && !do_push && !pop_empty && !dev_reset_q |=> index_q == $past(index_q) - 5'h01)
    else $error("pop did not retreat index");
  AST_ENTRY31_KEPT: assert property (@(posedge clk_in) disable iff (rst_in)
    do_push && index_q == RSP_INDEX_MAX |=> $stable(stack_q[31]))
    else $error("entry 31 overwritten");
  AST_IR_LOAD: assert property (@(posedge clk_in) disable iff (rst_in)
    ph.ph_four |=> ir_q == $past(fetch_word_in))
    else $error("instruction not latched");
endmodule

// ===== rsp_prog_mem_model.sv
// Behavioural program memory answering the core's fetch and table ports.
`timescale 1ns/1ps
module rsp_prog_mem_model (
  // Requests from the core.
  input wire logic [20:0] fetch_addr_in,
  input wire logic table_read_in,
  // Answers to the core.
  output logic [15:0] fetch_word_out,
  output logic [7:0] table_byte_out
);
  // The word follows the address, and the table byte differs outside a read strobe.
  // A stale or early sample therefore never matches what the bench expects.
  assign fetch_word_out = fetch_addr_in[16:1] ^ 16'hc3c3;
  assign table_byte_out = table_read_in ? 8'ha5 : 8'h5a;
endmodule

// ===== tb_top.sv
// Register-level testbench for the return stack and fast context core.
`timescale 1ns/1ps
module tb_top;
  import rsp_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0;
  logic [31:0] prdata_out, rdata;
  logic pready_out, pslverr_out, table_read_out, restore_out, operand_read_out;
  logic result_write_out, device_reset_out, phase_one_out, phase_four_out;
  logic [20:0] fetch_addr_out, last_addr;
  logic [15:0] fetch_word_in, instr_reg_out, last_word;
  logic [7:0] table_byte_in, status_restore_out, working_register_restore_out;
  logic [3:0] bank_select_register_restore_out;
  rsp_op_type exec_op_in = RSP_OP_NONE;
  logic exec_fast_in = 1'b0;
  logic irq_vector_in = 1'b0;
  logic [20:0] branch_target_in = 21'h000100;
  logic [20:0] irq_vector_addr_in = 21'h000008;
  logic [7:0] status_in = 8'h00;
  logic [7:0] working_register_in = 8'h00;
  logic [3:0] bank_select_register_in = 4'h0;
  logic rst_seen, res_seen, p4_prev;
  logic [19:0] res_val;
  logic [20:0] pc_pre, pc_seen, ret_addr;
  int bad_count = 0;
  int compares = 0;
  int n1, n4, nrd, nwr;

  initial forever #2 clk_in = ~clk_in;

  rsp_core uut (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .fetch_addr_out(fetch_addr_out), .fetch_word_in(fetch_word_in),
    .instr_reg_out(instr_reg_out), .table_read_out(table_read_out),
    .table_byte_in(table_byte_in), .exec_op_in(exec_op_in), .exec_fast_in(exec_fast_in),
    .branch_target_in(branch_target_in), .irq_vector_in(irq_vector_in),
    .irq_vector_addr_in(irq_vector_addr_in), .status_in(status_in),
    .working_register_in(working_register_in),
    .bank_select_register_in(bank_select_register_in), .restore_out(restore_out),
    .status_restore_out(status_restore_out),
    .working_register_restore_out(working_register_restore_out),
    .bank_select_register_restore_out(bank_select_register_restore_out),
    .operand_read_out(operand_read_out), .result_write_out(result_write_out),
    .device_reset_out(device_reset_out), .phase_one_out(phase_one_out),
    .phase_four_out(phase_four_out));

  rsp_prog_mem_model mem (.fetch_addr_in(fetch_addr_out), .table_read_in(table_read_out),
    .fetch_word_out(fetch_word_in), .table_byte_out(table_byte_in));

  task automatic summarize;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tmo(input int n);
    if (n >= 20) begin
      bad_count++;
      $display("[ERR] handshake wait expected 1 seen 0");
      summarize();
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    tmo(n);
    rdata = prdata_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdata);
  endtask

  // Holds an operation from phase_two through the phase_four edge, then watches
  // the following flushed cycle for the reset and restore pulses and the new fetch address.
  task automatic op(input rsp_op_type o, input logic f, input logic irq);
    int n;
    int k;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (phase_one_out !== 1'b1 && n < 20);
    tmo(n);
    exec_op_in <= o;
    exec_fast_in <= f;
    irq_vector_in <= irq;
    repeat (3) @(posedge clk_in);
    pc_pre = fetch_addr_out;
    exec_op_in <= RSP_OP_NONE;
    exec_fast_in <= 1'b0;
    irq_vector_in <= 1'b0;
    rst_seen = 1'b0;
    res_seen = 1'b0;
    k = 0;
    repeat (4) begin
      @(posedge clk_in);
      if (k == 0) pc_seen = fetch_addr_out;
      k++;
      if (device_reset_out === 1'b1) rst_seen = 1'b1;
      if (restore_out === 1'b1) begin
        res_seen = 1'b1;
        res_val = {status_restore_out, working_register_restore_out,
          bank_select_register_restore_out};
      end
    end
  endtask

  task automatic live(input logic [7:0] s, input logic [7:0] w, input logic [3:0] b);
    status_in <= s;
    working_register_in <= w;
    bank_select_register_in <= b;
  endtask

  initial begin
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    op(RSP_OP_NONE, 1'b0, 1'b0);
    rd(RSP_STACK_CTRL_ADDR, 32'h00, "ctrl_reset");
    rd(RSP_CONFIG_ADDR, 32'h01, "config_reset");
    rd(12'h0f0, 32'h00, "unmapped");
    wr(RSP_STACK_CTRL_ADDR, 32'hea);
    rd(RSP_STACK_CTRL_ADDR, 32'h0a, "ctrl_write");
    wr(RSP_CONFIG_ADDR, 32'h00);
    wr(RSP_STACK_CTRL_ADDR, 32'h03);
    op(RSP_OP_CALL, 1'b0, 1'b0);
    ret_addr = pc_pre;
    chk("call_target", 32'h100, {11'h0, pc_seen});
    rd(RSP_STACK_CTRL_ADDR, 32'h04, "push_index");
    op(RSP_OP_RETURN, 1'b0, 1'b0);
    chk("return_addr", {11'h0, ret_addr}, {11'h0, pc_seen});
    rd(RSP_STACK_CTRL_ADDR, 32'h03, "pop_index");
    wr(RSP_STACK_CTRL_ADDR, 32'h00);
    op(RSP_OP_RETURN, 1'b0, 1'b0);
    chk("underflow_no_reset", 32'h0, {31'h0, rst_seen});
    chk("underflow_pc", 32'h0, {11'h0, pc_seen});
    rd(RSP_STACK_CTRL_ADDR, 32'h40, "underflow");
    op(RSP_OP_NONE, 1'b0, 1'b0);
    rd(RSP_STACK_CTRL_ADDR, 32'h40, "underflow_kept");
    wr(RSP_STACK_CTRL_ADDR, 32'h00);
    rd(RSP_STACK_CTRL_ADDR, 32'h00, "flag_clear");
    wr(RSP_STACK_CTRL_ADDR, 32'h1e);
    op(RSP_OP_CALL, 1'b0, 1'b0);
    ret_addr = pc_pre;
    rd(RSP_STACK_CTRL_ADDR, 32'h9f, "full");
    op(RSP_OP_CALL, 1'b0, 1'b0);
    rd(RSP_STACK_CTRL_ADDR, 32'h9f, "overflow_hold");
    op(RSP_OP_RETURN, 1'b0, 1'b0);
    chk("entry31_kept", {11'h0, ret_addr}, {11'h0, pc_seen});
    rd(RSP_STACK_CTRL_ADDR, 32'h9e, "full_kept");
    wr(RSP_CONFIG_ADDR, 32'h01);
    wr(RSP_STACK_CTRL_ADDR, 32'h1e);
    op(RSP_OP_CALL, 1'b0, 1'b0);
    chk("full_reset", 32'h1, {31'h0, rst_seen});
    rd(RSP_STACK_CTRL_ADDR, 32'h80, "full_after_reset");
    op(RSP_OP_RETURN, 1'b0, 1'b0);
    chk("underflow_reset", 32'h1, {31'h0, rst_seen});
    rd(RSP_STACK_CTRL_ADDR, 32'hc0, "both_flags");
    wr(RSP_CONFIG_ADDR, 32'h00);
    wr(RSP_STACK_CTRL_ADDR, 32'h00);
    live(8'h5a, 8'h3c, 4'h9);
    op(RSP_OP_CALL, 1'b1, 1'b0);
    live(8'h11, 8'h22, 4'h3);
    op(RSP_OP_RETURN, 1'b1, 1'b0);
    chk("fast_return", {12'h1, 20'h5a3c9}, {11'h0, res_seen, res_val});
    live(8'ha1, 8'hb2, 4'h5);
    op(RSP_OP_NONE, 1'b0, 1'b1);
    live(8'hc3, 8'hd4, 4'h6);
    op(RSP_OP_NONE, 1'b0, 1'b1);
    live(8'h00, 8'h00, 4'h0);
    op(RSP_OP_RETURN_FROM_INTERRUPT, 1'b1, 1'b0);
    chk("fast_return_from_interrupt", {12'h1, 20'hc3d46}, {11'h0, res_seen, res_val});
    rd(RSP_STACK_CTRL_ADDR, 32'h01, "irq_push");
    wr(RSP_TABLE_PTR_ADDR, 32'h10);
    apb(1'b0, RSP_TABLE_LATCH_ADDR, 32'h0);
    rd(RSP_TABLE_LATCH_ADDR, 32'ha5, "table_latch");
    rd(RSP_TABLE_PTR_ADDR, 32'h12, "table_pointer");
    op(RSP_OP_GOTO, 1'b0, 1'b0);
    chk("goto_target", 32'h100, {11'h0, pc_seen});
    // Two phase_one steps lie between the jump and the add, so the base is the target plus four.
    live(8'h00, 8'h06, 4'h0);
    op(RSP_OP_ADD_PCL, 1'b0, 1'b0);
    chk("computed_jump", 32'h10a, {11'h0, pc_seen});
    n1 = 0;
    n4 = 0;
    nrd = 0;
    nwr = 0;
    p4_prev = 1'b0;
    repeat (40) begin
      @(posedge clk_in);
      if (p4_prev === 1'b1) chk("instr_reg", {16'h0, last_word}, {16'h0, instr_reg_out});
      p4_prev = phase_four_out;
      if (phase_four_out === 1'b1) begin
        if (n4 > 0) chk("pc_step", {11'h0, last_addr + RSP_PC_STEP}, {11'h0, fetch_addr_out});
        last_addr = fetch_addr_out;
        last_word = fetch_word_in;
        n4++;
      end
      if (phase_one_out === 1'b1) n1++;
      if (operand_read_out === 1'b1) nrd++;
      if (result_write_out === 1'b1) nwr++;
    end
    chk("phase_one_count", 32'd10, n1);
    chk("phase_four_count", 32'd10, n4);
    chk("operand_reads", 32'd10, nrd);
    chk("result_writes", 32'd10, nwr);
    summarize();
  end
endmodule
